// >>> common/fsog_pkg.sv
// shared constants and types for the fine serial output generator
package fsog_pkg;

    // ****************************************************************
    // word and memory geometry
    // ****************************************************************
    localparam int          FSOG_WORD_BITS   = 40;
    localparam int          FSOG_MEM_DEPTH   = 2048;
    localparam logic [10:0] FSOG_MEM_LAST    = 11'h7FF;
    localparam logic [15:0] FSOG_STEP_CYCLE  = 16'h0028;

    // ****************************************************************
    // source mapping codes
    // ****************************************************************
    localparam logic [5:0]  FSOG_MAP_DBUS_LO = 6'h20;
    localparam logic [5:0]  FSOG_MAP_DBUS_HI = 6'h27;
    localparam logic [5:0]  FSOG_MAP_PRE_LO  = 6'h28;
    localparam logic [5:0]  FSOG_MAP_PRE_HI  = 6'h2A;
    localparam logic [5:0]  FSOG_MAP_ONE     = 6'h3E;
    localparam logic [5:0]  FSOG_MAP_ZERO    = 6'h3F;
    localparam logic [4:0]  FSOG_UNIV_CLK_A  = 5'h10;
    localparam logic [4:0]  FSOG_UNIV_CLK_B  = 5'h11;

    // ****************************************************************
    // register offsets
    // ****************************************************************
    localparam logic [7:0]  FSOG_OFF_CTRL    = 8'h00;
    localparam logic [7:0]  FSOG_OFF_STATUS  = 8'h04;
    localparam logic [7:0]  FSOG_OFF_P00_LO  = 8'h08;
    localparam logic [7:0]  FSOG_OFF_P00_HI  = 8'h0C;
    localparam logic [7:0]  FSOG_OFF_P01_LO  = 8'h10;
    localparam logic [7:0]  FSOG_OFF_P01_HI  = 8'h14;
    localparam logic [7:0]  FSOG_OFF_P11_LO  = 8'h18;
    localparam logic [7:0]  FSOG_OFF_P11_HI  = 8'h1C;
    localparam logic [7:0]  FSOG_OFF_P10_LO  = 8'h20;
    localparam logic [7:0]  FSOG_OFF_P10_HI  = 8'h24;
    localparam logic [7:0]  FSOG_OFF_HIGH    = 8'h28;
    localparam logic [7:0]  FSOG_OFF_LOW     = 8'h2C;
    localparam logic [7:0]  FSOG_OFF_SAMPLES = 8'h30;
    localparam logic [7:0]  FSOG_OFF_MADDR   = 8'h34;
    localparam logic [7:0]  FSOG_OFF_MLO     = 8'h38;
    localparam logic [7:0]  FSOG_OFF_MHI     = 8'h3C;

    // ****************************************************************
    // control and status field positions
    // ****************************************************************
    localparam int          FSOG_CTRL_MODE   = 0;
    localparam int          FSOG_CTRL_RECYC  = 2;
    localparam int          FSOG_CTRL_TLVL   = 3;
    localparam int          FSOG_CTRL_MAP    = 8;
    localparam int          FSOG_CTRL_TPOS   = 16;
    localparam int          FSOG_STAT_RUN    = 2;
    localparam int          FSOG_STAT_LVL    = 3;
    localparam int          FSOG_STAT_IDX    = 16;

    // ****************************************************************
    // reset values
    // ****************************************************************
    localparam logic [15:0] FSOG_RST_HALF    = 16'h0028;
    localparam logic [11:0] FSOG_RST_SAMPLES = 12'h000;

    typedef enum logic [1:0] {
        FSOG_MODE_PULSE   = 2'b00,
        FSOG_MODE_FREQ    = 2'b01,
        FSOG_MODE_PATTERN = 2'b10
    } fsog_mode_e;

endpackage

// >>> hw/fsog_source_map.sv
// output mapping selector: picks one source level per event clock cycle
`timescale 1ns/1ps
`default_nettype none

module fsog_source_map (
    input  wire logic        ref_clk,
    input  wire logic        rst,
    input  wire logic [5:0]  map_sel,
    input  wire logic [31:0] pulse_gen,
    input  wire logic [7:0]  distributed_bus,
    input  wire logic [2:0]  prescaler,
    output logic             src_q
);

    typedef struct packed {
        logic src_q;
    } fsog_map_state_s;

    fsog_map_state_s s_q;
    fsog_map_state_s s_d;

    // ****************************************************************
    // selection
    // ****************************************************************
    // reserved codes fall to low so a stale map never glitches the output
    always_comb begin
        s_d = s_q;
        s_d.src_q = 1'b0;
        if (map_sel < fsog_pkg::FSOG_MAP_DBUS_LO) begin
            s_d.src_q = pulse_gen[map_sel[4:0]];
        end else if (map_sel <= fsog_pkg::FSOG_MAP_DBUS_HI) begin
            s_d.src_q = distributed_bus[map_sel[2:0]];
        end else if (map_sel <= fsog_pkg::FSOG_MAP_PRE_HI) begin
            s_d.src_q = prescaler[2'(map_sel - fsog_pkg::FSOG_MAP_PRE_LO)];
        end else if (map_sel == fsog_pkg::FSOG_MAP_ONE) begin
            s_d.src_q = 1'b1;
        end else if (map_sel == fsog_pkg::FSOG_MAP_ZERO) begin
            s_d.src_q = 1'b0;
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign src_q = s_q.src_q;

    // ****************************************************************
    // checks
    // ****************************************************************
    property p_map_zero;
        @(posedge ref_clk) disable iff (rst)
        (map_sel == fsog_pkg::FSOG_MAP_ZERO) |=> !src_q;
    endproperty
    a_map_zero: assert property (p_map_zero) else $error("map 63 not low");

    property p_map_dbus;
        @(posedge ref_clk) disable iff (rst)
        (map_sel >= fsog_pkg::FSOG_MAP_DBUS_LO && map_sel <= fsog_pkg::FSOG_MAP_DBUS_HI)
            |=> src_q == $past(distributed_bus[map_sel[2:0]]);
    endproperty
    a_map_dbus: assert property (p_map_dbus) else $error("bus bit map wrong");

endmodule

`default_nettype wire

// >>> hw/fsog_top.sv
// fine serial output generator: pulse, frequency and pattern word source
//
// Contract
// - one 40-bit serial word leaves per event clock cycle.
// - mode field picks pulse, pattern playback or frequency mode.
// - pulse state is previous and current source: 00 low, 01 rise, 11 high, 10 fall.
// - steady low repeats the steady-low word.
// - rising cycle sends the rising-edge word once.
// - steady high repeats the steady-high word.
// - falling cycle sends the falling-edge word once.
// - source chosen by mapping field; backplane clocks use universal entries 16 and 17.
// - frequency mode high and low times count in fortieths of a cycle.
// - frequency generator syncs on rising edges of the mapped source.
// - sync edge loads level from trigger level and counter from trigger position.
// - trigger level and trigger position live in the control register.
// - patterns are whole 40-bit words, memory holds 2048 of them.
// - pattern trigger comes from any mapped source.
// - trigger plays words from position 0 for the sample length count.
// - single mode then sends word 2047 until the next trigger.
// - mapping value 63 forces the source low.
// - map 32..39 pick bus bits 0..7, 40..42 pick prescalers 0..2.
//
// Our own choices: the plain strobed port and the address map.
`timescale 1ns/1ps
`default_nettype none

module fsog_top #(
    parameter logic [4:0] UNIV_ENTRY = fsog_pkg::FSOG_UNIV_CLK_A
) (
    input  wire logic        ref_clk,
    input  wire logic        rst,
    input  wire logic [7:0]  reg_addr,
    input  wire logic [31:0] reg_wdata,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    output logic [31:0]      reg_rdata,
    input  wire logic [31:0] pulse_gen,
    input  wire logic [7:0]  distributed_bus,
    input  wire logic [2:0]  prescaler,
    output logic [39:0]      serial_word
);

    // ****************************************************************
    // state
    // ****************************************************************
    typedef struct packed {
        fsog_pkg::fsog_mode_e   mode_q;
        logic                   recycle_q;
        logic                   trigger_level_select_q;
        logic [5:0]             map_q;
        logic [15:0]            trig_pos_q;
        logic [3:0][39:0]       pat_q;
        logic [15:0]            high_q;
        logic [15:0]            low_q;
        logic [11:0]            samples_q;
        logic [10:0]            maddr_q;
        logic [31:0]            mstage_q;
        logic [2047:0][39:0]    mem_q;
        logic                   prev_q;
        logic                   lvl_q;
        logic [15:0]            cnt_q;
        logic                   run_q;
        logic [10:0]            idx_q;
        logic [39:0]            word_q;
        logic [31:0]            rdata_q;
    } fsog_state_s;

    fsog_state_s s_q;
    fsog_state_s s_d;

    logic        src;
    logic        trig;
    logic [1:0]  pstate;
    logic [39:0] freq_word;

    // ****************************************************************
    // source selection
    // ****************************************************************
    // one mapper per channel; the universal entry only labels which slot it serves
    fsog_source_map u_map (
        .ref_clk         (ref_clk),
        .rst             (rst),
        .map_sel         (s_q.map_q),
        .pulse_gen       (pulse_gen),
        .distributed_bus (distributed_bus),
        .prescaler       (prescaler),
        .src_q           (src)
    );

    // state code and rising edge of the mapped source
    assign pstate = {s_q.prev_q, src};
    assign trig   = src & ~s_q.prev_q;

    // ****************************************************************
    // frequency word: bits before the counter expiry keep the level
    // ****************************************************************
    for (genvar gi = 0; gi < fsog_pkg::FSOG_WORD_BITS; gi++) begin : g_freq
        assign freq_word[gi] = s_q.lvl_q ^ (s_q.cnt_q <= 16'(gi));
    end

    // ****************************************************************
    // next state
    // ****************************************************************
    always_comb begin
        logic [15:0] nlen;
        logic [1:0]  pk;
        nlen = 16'h0000;
        pk   = 2'b00;
        s_d  = s_q;
        s_d.prev_q  = src;
        s_d.rdata_q = 32'h0000_0000;

        // register writes
        if (reg_wr) begin
            pk = reg_addr[4:3] - 2'b01;
            unique case (reg_addr)
                fsog_pkg::FSOG_OFF_CTRL: begin
                    s_d.mode_q    = fsog_pkg::fsog_mode_e'(reg_wdata[fsog_pkg::FSOG_CTRL_MODE +: 2]);
                    s_d.recycle_q = reg_wdata[fsog_pkg::FSOG_CTRL_RECYC];
                    s_d.trigger_level_select_q = reg_wdata[fsog_pkg::FSOG_CTRL_TLVL];
                    s_d.map_q      = reg_wdata[fsog_pkg::FSOG_CTRL_MAP +: 6];
                    s_d.trig_pos_q = reg_wdata[fsog_pkg::FSOG_CTRL_TPOS +: 16];
                end
                fsog_pkg::FSOG_OFF_P00_LO, fsog_pkg::FSOG_OFF_P01_LO,
                fsog_pkg::FSOG_OFF_P11_LO, fsog_pkg::FSOG_OFF_P10_LO: begin
                    s_d.pat_q[{pk[1], pk[1] ^ pk[0]}][31:0] = reg_wdata;
                end
                fsog_pkg::FSOG_OFF_P00_HI, fsog_pkg::FSOG_OFF_P01_HI,
                fsog_pkg::FSOG_OFF_P11_HI, fsog_pkg::FSOG_OFF_P10_HI: begin
                    s_d.pat_q[{pk[1], pk[1] ^ pk[0]}][39:32] = reg_wdata[7:0];
                end
                fsog_pkg::FSOG_OFF_HIGH:    s_d.high_q    = reg_wdata[15:0];
                fsog_pkg::FSOG_OFF_LOW:     s_d.low_q     = reg_wdata[15:0];
                fsog_pkg::FSOG_OFF_SAMPLES: s_d.samples_q = reg_wdata[11:0];
                fsog_pkg::FSOG_OFF_MADDR:   s_d.maddr_q   = reg_wdata[10:0];
                fsog_pkg::FSOG_OFF_MLO:     s_d.mstage_q  = reg_wdata;
                fsog_pkg::FSOG_OFF_MHI: begin
                    // high half commits the word and steps the address
                    s_d.mem_q[s_q.maddr_q] = {reg_wdata[7:0], s_q.mstage_q};
                    s_d.maddr_q = s_q.maddr_q + 11'h001;
                end
                default: ;
            endcase
        end

        // register reads, answered in the following cycle only
        if (reg_rd) begin
            pk = reg_addr[4:3] - 2'b01;
            unique case (reg_addr)
                fsog_pkg::FSOG_OFF_CTRL: begin
                    s_d.rdata_q[fsog_pkg::FSOG_CTRL_MODE +: 2]  = s_q.mode_q;
                    s_d.rdata_q[fsog_pkg::FSOG_CTRL_RECYC]      = s_q.recycle_q;
                    s_d.rdata_q[fsog_pkg::FSOG_CTRL_TLVL]       = s_q.trigger_level_select_q;
                    s_d.rdata_q[fsog_pkg::FSOG_CTRL_MAP +: 6]   = s_q.map_q;
                    s_d.rdata_q[fsog_pkg::FSOG_CTRL_TPOS +: 16] = s_q.trig_pos_q;
                end
                fsog_pkg::FSOG_OFF_STATUS: begin
                    s_d.rdata_q[1:0] = pstate;
                    s_d.rdata_q[fsog_pkg::FSOG_STAT_RUN]       = s_q.run_q;
                    s_d.rdata_q[fsog_pkg::FSOG_STAT_LVL]       = s_q.lvl_q;
                    s_d.rdata_q[fsog_pkg::FSOG_STAT_IDX +: 11] = s_q.idx_q;
                end
                fsog_pkg::FSOG_OFF_P00_LO, fsog_pkg::FSOG_OFF_P01_LO,
                fsog_pkg::FSOG_OFF_P11_LO, fsog_pkg::FSOG_OFF_P10_LO: begin
                    s_d.rdata_q = s_q.pat_q[{pk[1], pk[1] ^ pk[0]}][31:0];
                end
                fsog_pkg::FSOG_OFF_P00_HI, fsog_pkg::FSOG_OFF_P01_HI,
                fsog_pkg::FSOG_OFF_P11_HI, fsog_pkg::FSOG_OFF_P10_HI: begin
                    s_d.rdata_q[7:0] = s_q.pat_q[{pk[1], pk[1] ^ pk[0]}][39:32];
                end
                fsog_pkg::FSOG_OFF_HIGH:    s_d.rdata_q[15:0] = s_q.high_q;
                fsog_pkg::FSOG_OFF_LOW:     s_d.rdata_q[15:0] = s_q.low_q;
                fsog_pkg::FSOG_OFF_SAMPLES: s_d.rdata_q[11:0] = s_q.samples_q;
                fsog_pkg::FSOG_OFF_MADDR:   s_d.rdata_q[10:0] = s_q.maddr_q;
                fsog_pkg::FSOG_OFF_MLO:     s_d.rdata_q       = s_q.mstage_q;
                default: ;
            endcase
        end

        // word generation, one 40-bit word per cycle
        unique case (s_q.mode_q)
            fsog_pkg::FSOG_MODE_PULSE: begin
                s_d.word_q = s_q.pat_q[pstate];
            end
            fsog_pkg::FSOG_MODE_FREQ: begin
                s_d.word_q = freq_word;
                // high and low times of at least 40 mean one toggle per word at most
                if (s_q.cnt_q > fsog_pkg::FSOG_STEP_CYCLE) begin
                    s_d.cnt_q = s_q.cnt_q - fsog_pkg::FSOG_STEP_CYCLE;
                end else begin
                    nlen = s_q.lvl_q ? s_q.low_q : s_q.high_q;
                    s_d.lvl_q = ~s_q.lvl_q;
                    s_d.cnt_q = nlen - (fsog_pkg::FSOG_STEP_CYCLE - s_q.cnt_q);
                end
                if (trig) begin
                    s_d.lvl_q = s_q.trigger_level_select_q;
                    s_d.cnt_q = s_q.trig_pos_q;
                end
            end
            fsog_pkg::FSOG_MODE_PATTERN: begin
                if (s_q.run_q) begin
                    s_d.word_q = s_q.mem_q[s_q.idx_q];
                    if ({1'b0, s_q.idx_q} == s_q.samples_q - 12'h001) begin
                        s_d.idx_q = 11'h000;
                        s_d.run_q = s_q.recycle_q;
                    end else begin
                        s_d.idx_q = s_q.idx_q + 11'h001;
                    end
                end else begin
                    s_d.word_q = s_q.mem_q[fsog_pkg::FSOG_MEM_LAST];
                end
                // a trigger restarts playback even mid-pattern
                if (trig && s_q.samples_q != 12'h000) begin
                    s_d.run_q = 1'b1;
                    s_d.idx_q = 11'h000;
                end
            end
            default: s_d.word_q = s_q.pat_q[pstate];
        endcase
    end

    // ****************************************************************
    // registers
    // ****************************************************************
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            s_q           <= '0;
            s_q.map_q     <= fsog_pkg::FSOG_MAP_ZERO;
            s_q.high_q    <= fsog_pkg::FSOG_RST_HALF;
            s_q.low_q     <= fsog_pkg::FSOG_RST_HALF;
            s_q.cnt_q     <= fsog_pkg::FSOG_RST_HALF;
            s_q.samples_q <= fsog_pkg::FSOG_RST_SAMPLES;
        end else begin
            s_q <= s_d;
        end
    end

    assign serial_word = s_q.word_q;
    assign reg_rdata   = s_q.rdata_q;

    // ****************************************************************
    // checks
    // ****************************************************************
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);

    property p_low;
        (s_q.mode_q == fsog_pkg::FSOG_MODE_PULSE && pstate == 2'b00)
            |=> serial_word == $past(s_q.pat_q[0]);
    endproperty
    a_low: assert property (p_low) else $error("steady low word wrong");

    property p_rise;
        (s_q.mode_q == fsog_pkg::FSOG_MODE_PULSE && !s_q.prev_q && src)
            |=> serial_word == $past(s_q.pat_q[1]);
    endproperty
    a_rise: assert property (p_rise) else $error("rising word wrong");

    property p_high;
        (s_q.mode_q == fsog_pkg::FSOG_MODE_PULSE && s_q.prev_q && src)
            |=> serial_word == $past(s_q.pat_q[3]);
    endproperty
    a_high: assert property (p_high) else $error("steady high word wrong");

    property p_fall;
        (s_q.mode_q == fsog_pkg::FSOG_MODE_PULSE && s_q.prev_q && !src)
            |=> serial_word == $past(s_q.pat_q[2]);
    endproperty
    a_fall: assert property (p_fall) else $error("falling word wrong");

    property p_sync;
        (s_q.mode_q == fsog_pkg::FSOG_MODE_FREQ && trig)
            |=> s_q.lvl_q == $past(s_q.trigger_level_select_q)
                && s_q.cnt_q == $past(s_q.trig_pos_q);
    endproperty
    a_sync: assert property (p_sync) else $error("sync load wrong");

    property p_steady_freq;
        (s_q.mode_q == fsog_pkg::FSOG_MODE_FREQ && !trig && s_q.cnt_q > 16'h0028)
            |=> s_q.cnt_q == $past(s_q.cnt_q) - 16'h0028
                && serial_word == {40{$past(s_q.lvl_q)}};
    endproperty
    a_steady_freq: assert property (p_steady_freq) else $error("freq count wrong");

    property p_start;
        (s_q.mode_q == fsog_pkg::FSOG_MODE_PATTERN && trig && s_q.samples_q != 12'h000)
            ##1 (s_q.mode_q == fsog_pkg::FSOG_MODE_PATTERN && !trig)
            |=> serial_word == $past(s_q.mem_q[0]);
    endproperty
    a_start: assert property (p_start) else $error("pattern not from zero");

    property p_idle;
        (s_q.mode_q == fsog_pkg::FSOG_MODE_PATTERN && !s_q.run_q)
            |=> serial_word == $past(s_q.mem_q[2047]);
    endproperty
    a_idle: assert property (p_idle) else $error("idle word not 2047");

    property p_recycle;
        (s_q.mode_q == fsog_pkg::FSOG_MODE_PATTERN && s_q.run_q && s_q.recycle_q && !trig
            && {1'b0, s_q.idx_q} == s_q.samples_q - 12'h001)
            |=> s_q.run_q && s_q.idx_q == 11'h000;
    endproperty
    a_recycle: assert property (p_recycle) else $error("recycle did not wrap");

    // shorthands keep the pattern checks short enough to read
    logic pat_mode;
    logic pat_last;
    assign pat_mode = s_q.mode_q == fsog_pkg::FSOG_MODE_PATTERN;
    assign pat_last = {1'b0, s_q.idx_q} == s_q.samples_q - 12'h001;

    property p_ctrl_wr;
        (reg_wr && reg_addr == fsog_pkg::FSOG_OFF_CTRL)
            |=> s_q.trig_pos_q == $past(reg_wdata[fsog_pkg::FSOG_CTRL_TPOS +: 16])
                && s_q.trigger_level_select_q == $past(reg_wdata[fsog_pkg::FSOG_CTRL_TLVL]);
    endproperty
    a_ctrl_wr: assert property (p_ctrl_wr) else $error("control not stored");

    // the address steps after each commit so software can stream words
    property p_mem_wr;
        (reg_wr && reg_addr == fsog_pkg::FSOG_OFF_MHI)
            |=> s_q.mem_q[$past(s_q.maddr_q)] == {$past(reg_wdata[7:0]), $past(s_q.mstage_q)}
                && s_q.maddr_q == $past(s_q.maddr_q) + 11'h001;
    endproperty
    a_mem_wr: assert property (p_mem_wr) else $error("pattern word not committed");

    property p_trig_start;
        (pat_mode && trig && s_q.samples_q != 12'h000) |=> s_q.run_q && s_q.idx_q == 11'h000;
    endproperty
    a_trig_start: assert property (p_trig_start) else $error("trigger did not start");

    property p_advance;
        (pat_mode && s_q.run_q && !trig && !pat_last)
            |=> s_q.idx_q == $past(s_q.idx_q) + 11'h001;
    endproperty
    a_advance: assert property (p_advance) else $error("pattern index stalled");

    property p_single_end;
        (pat_mode && s_q.run_q && !s_q.recycle_q && !trig && pat_last) |=> !s_q.run_q;
    endproperty
    a_single_end: assert property (p_single_end) else $error("single pattern ran on");

    property p_toggle;
        (s_q.mode_q == fsog_pkg::FSOG_MODE_FREQ && !trig
            && s_q.cnt_q <= fsog_pkg::FSOG_STEP_CYCLE) |=> s_q.lvl_q != $past(s_q.lvl_q);
    endproperty
    a_toggle: assert property (p_toggle) else $error("level did not toggle");

endmodule

`default_nettype wire

// >>> tb/fsog_top_tb.sv
// self-checking testbench for the fine serial output generator
`timescale 1ns/1ps
`default_nettype none

module fsog_top_tb;
    logic        ref_clk;
    logic        rst;
    logic [7:0]  reg_addr;
    logic [31:0] reg_wdata;
    logic        reg_wr;
    logic        reg_rd;
    logic [31:0] reg_rdata;
    logic [31:0] pulse_gen;
    logic [7:0]  distributed_bus;
    logic [2:0]  prescaler;
    logic [39:0] serial_word;
    int          error_cnt;
    int          comparisons;
    logic [31:0] d;
    logic [39:0] w [4];
    logic [39:0] m [4];
    logic [39:0] fq [6];
    logic [5:0]  mcode [7];
    int          mexp [7];

    fsog_top fsog_top_inst (
        .ref_clk         (ref_clk),
        .rst             (rst),
        .reg_addr        (reg_addr),
        .reg_wdata       (reg_wdata),
        .reg_wr          (reg_wr),
        .reg_rd          (reg_rd),
        .reg_rdata       (reg_rdata),
        .pulse_gen       (pulse_gen),
        .distributed_bus (distributed_bus),
        .prescaler       (prescaler),
        .serial_word     (serial_word)
    );

    // ****************************************
    // clock, watchdog and common tasks
    // ****************************************
    initial begin
        ref_clk = 1'b0;
        forever #10 ref_clk = ~ref_clk;
    end

    // a hang anywhere ends the run as a failure
    initial begin
        #400000;
        error_cnt++;
        end_of_test();
    end

    task automatic end_of_test;
        $display("errors %0d comparisons %0d", error_cnt, comparisons);
        if (error_cnt == 0 && comparisons > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    task automatic chk(input string name, input logic [39:0] exp, input logic [39:0] got);
        comparisons++;
        if (got !== exp) begin
            error_cnt++;
            $display("[ERR] %s expected %h seen %h", name, exp, got);
        end
    endtask

    // strobe drops one edge later, so calls back to back leave a gap
    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        @(posedge ref_clk);
        reg_wr    <= 1'b1;
        reg_addr  <= a;
        reg_wdata <= v;
        @(posedge ref_clk);
        reg_wr    <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, output logic [31:0] v);
        @(posedge ref_clk);
        reg_rd   <= 1'b1;
        reg_addr <= a;
        @(posedge ref_clk);
        reg_rd   <= 1'b0;
        @(negedge ref_clk);
        v = reg_rdata;
    endtask

    // low 32 bits go to the LO offset, top 8 bits to LO plus 4
    task automatic wword(input logic [7:0] a, input logic [39:0] v);
        wr(a, v[31:0]);
        wr(a + 8'h04, {24'h000000, v[39:32]});
    endtask

    function automatic logic [31:0] ctl(input logic [1:0] md, input logic rec,
                                        input logic lvl, input logic [5:0] map,
                                        input logic [15:0] pos);
        ctl = {pos, 2'b00, map, 4'h0, lvl, rec, md};
    endfunction

    task automatic set_src(input logic v);
        @(posedge ref_clk);
        distributed_bus[0] <= v;
    endtask

    // bounded search for the first expected word, then stop on a miss
    task automatic seek(input string name, input logic [39:0] exp);
        @(negedge ref_clk);
        for (int i = 0; i < 24 && serial_word !== exp; i++) begin
            @(negedge ref_clk);
        end
        chk(name, exp, serial_word);
        if (serial_word !== exp) end_of_test();
    endtask

    // ****************************************
    // main sequence
    // ****************************************
    initial begin
        error_cnt = 0;
        comparisons = 0;
        rst = 1'b1;
        reg_addr = 8'h00;
        reg_wdata = 32'h00000000;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        pulse_gen = 32'h00000000;
        distributed_bus = 8'h00;
        prescaler = 3'h0;
        w = '{40'h1122334455, 40'h66778899AA, 40'hBBCCDDEEFF, 40'h0123456789};
        m = '{40'hA0A0A0A0A0, 40'h0505050505, 40'hC3C3C3C3C3, 40'h7E7E7E7E7E};
        fq = '{40'hFFFFFFFC00, 40'hFFFFFFFFFF, 40'h00000003FF,
               40'h003FFFFFFF, 40'hFFC0000000, 40'hFFFFFFFFFF};
        mcode = '{6'h05, 6'h27, 6'h2A, 6'h3E, 6'h3F, 6'h20, 6'h04};
        mexp = '{2, 2, 2, 2, 0, 0, 0};
        repeat (8) @(posedge ref_clk);
        rst <= 1'b0;
        // register access, unmapped place and control fields
        rd(fsog_pkg::FSOG_OFF_HIGH, d);
        chk("high reset", {24'h000000, fsog_pkg::FSOG_RST_HALF}, {8'h00, d});
        wr(fsog_pkg::FSOG_OFF_CTRL, ctl(2'h0, 1'b0, 1'b1, 6'h20, 16'h1234));
        rd(fsog_pkg::FSOG_OFF_CTRL, d);
        chk("ctrl", {8'h00, ctl(2'h0, 1'b0, 1'b1, 6'h20, 16'h1234)}, {8'h00, d});
        rd(8'h40, d);
        chk("unmapped", 40'h0000000000, {8'h00, d});
        // pulse mode: four states, then a one-cycle pulse
        for (int i = 0; i < 4; i++) wword(fsog_pkg::FSOG_OFF_P00_LO + 8'(8 * i), w[i]);
        repeat (4) @(negedge ref_clk);
        chk("steady low", w[0], serial_word);
        set_src(1'b1);
        repeat (2) @(posedge ref_clk);
        @(negedge ref_clk);
        chk("rising", w[1], serial_word);
        @(negedge ref_clk);
        chk("high", w[2], serial_word);
        @(negedge ref_clk);
        chk("high again", w[2], serial_word);
        set_src(1'b0);
        repeat (2) @(posedge ref_clk);
        @(negedge ref_clk);
        chk("falling", w[3], serial_word);
        @(negedge ref_clk);
        chk("low again", w[0], serial_word);
        set_src(1'b1);
        set_src(1'b0);
        @(posedge ref_clk);
        @(negedge ref_clk);
        chk("short rise", w[1], serial_word);
        @(negedge ref_clk);
        chk("short fall", w[3], serial_word);
        // source mapping over pulse, bus, prescaler and forced codes; odd steps use mode 3
        @(posedge ref_clk);
        pulse_gen <= 32'h00000020;
        distributed_bus <= 8'h80;
        prescaler <= 3'b100;
        for (int i = 0; i < 7; i++) begin
            wr(fsog_pkg::FSOG_OFF_CTRL, ctl(2'(3 * (i % 2)), 1'b0, 1'b0, mcode[i], 16'h0000));
            repeat (4) @(negedge ref_clk);
            chk("map", w[mexp[i]], serial_word);
        end
        // pattern memory: words 0..2 and the last place
        wr(fsog_pkg::FSOG_OFF_MADDR, 32'h00000000);
        for (int i = 0; i < 3; i++) wword(fsog_pkg::FSOG_OFF_MLO, m[i]);
        wr(fsog_pkg::FSOG_OFF_MADDR, 32'h000007FF);
        wword(fsog_pkg::FSOG_OFF_MLO, m[3]);
        wr(fsog_pkg::FSOG_OFF_SAMPLES, 32'h00000003);
        for (int r = 0; r < 2; r++) begin
            wr(fsog_pkg::FSOG_OFF_CTRL, ctl(2'h2, r[0], 1'b0, 6'h20, 16'h0000));
            set_src(1'b1);
            seek("pattern start", m[0]);
            for (int i = 1; i < 6; i++) begin
                @(negedge ref_clk);
                chk("pattern", (r == 0) ? m[(i < 3) ? i : 3] : m[i % 3], serial_word);
            end
            set_src(1'b0);
        end
        // frequency mode: high 80, low 40, two sync phases
        wr(fsog_pkg::FSOG_OFF_HIGH, 32'h00000050);
        wr(fsog_pkg::FSOG_OFF_LOW, 32'h00000028);
        for (int t = 0; t < 2; t++) begin
            wr(fsog_pkg::FSOG_OFF_CTRL, ctl(2'h1, 1'b0, t[0], 6'h20, t ? 16'h001E : 16'h000A));
            set_src(1'b1);
            seek("freq sync", fq[3 * t]);
            for (int k = 1; k < 4; k++) begin
                @(negedge ref_clk);
                chk("freq", fq[3 * t + k % 3], serial_word);
            end
            set_src(1'b0);
            repeat (3) @(posedge ref_clk);
        end
        end_of_test();
    end
endmodule

`default_nettype wire
